// ### hw/hpi_pkg.sv
// constants and types shared by both ends of the host port
package hpi_pkg;
    localparam int unsigned DATA_W      = 16;
    localparam int unsigned REG_W       = 32;
    localparam int unsigned CODE_W      = 6;
    localparam int unsigned IDX_USED_W  = 8;
    localparam int unsigned HSK_W       = 16;
    localparam int unsigned CODE_LSB    = 2;
    localparam int unsigned CODE_MSB    = 7;
    localparam logic [7:0]  IDX_RESET   = 8'h00;
    localparam logic [15:0] HSK_RESET   = 16'h0000;
    localparam logic [1:0]  HALF_FIRST  = 2'h0;
    localparam logic [1:0]  HALF_SECOND = 2'h2;

    typedef enum logic [5:0] {
        HPI_GEN_STATUS  = 6'h00,
        HPI_STAT_CTRL   = 6'h01,
        HPI_MEM_CTRL    = 6'h02,
        HPI_IN_IRQ      = 6'h03,
        HPI_OUT_IRQ     = 6'h04,
        HPI_RAM_ADDR    = 6'h05,
        HPI_DATA_WINDOW = 6'h06,
        HPI_BOOT_CTRL   = 6'h0f
    } hpi_code_t;

    // host sequencer states, gray along idle -> setup -> strobe -> hold
    typedef enum logic [1:0] {
        HPI_IDLE   = 2'b00,
        HPI_SETUP  = 2'b01,
        HPI_STROBE = 2'b11,
        HPI_HOLD   = 2'b10
    } hpi_host_state_t;

    // strobe widths in ns and in clock cycles at 100 ns period
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned STROBE_NS     = 400;
    localparam int unsigned STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0]  STROBE_CNT    = 4'(STROBE_CYC);
endpackage

// ### hw/hpi_if.sv
// parallel host port wires between host and device
`timescale 1ns/1ps
interface hpi_if;
    logic        port_chip_select_n;
    logic        register_select_pin;
    logic        port_write_strobe_n;
    logic        port_read_strobe_n;
    logic [15:0] host_data_out;
    logic        host_data_oe;
    logic [15:0] dev_data_out;
    logic        dev_data_oe;
    logic [15:0] data_bus;

    assign data_bus = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : 16'h0000);

    modport device (
        input  port_chip_select_n,
        input  register_select_pin,
        input  port_write_strobe_n,
        input  port_read_strobe_n,
        input  data_bus,
        output dev_data_out,
        output dev_data_oe
    );
    modport host (
        output port_chip_select_n,
        output register_select_pin,
        output port_write_strobe_n,
        output port_read_strobe_n,
        output host_data_out,
        output host_data_oe,
        input  data_bus
    );
endinterface

// ### hw/hpi_device.sv
// device end: index register, handshake status and data-window half-word walk
//
// Summary of operation
// RQ1: index register picks target when select low
// RQ2: on-chip software reads index, cannot write
// RQ3: index written only by host, select high
// RQ4: unused upper bits read zero, write zero
// RQ5: six-bit target code decodes eight registers
// RQ6: host loads only the eight listed codes
// RQ7: order clear: 00 upper half, 10 lower
// RQ8: order set: 00 lower half, 10 upper
// RQ9: data window access toggles selector 00/10
// RQ10: sixteen handshake bits, both sides read/write
// RQ11: host reads status directly or through index
// RQ12: host writes status only through index
// RQ13: handshake bits clear on power-on reset only
// RQ14: strobe and select combinations pick operation
// RQ15: chip select high or strobes high: nop
// RQ16: strobes synchronised, one commit per write
`timescale 1ns/1ps
module hpi_device (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        por_rst,
    hpi_if.device            port,
    input  wire logic        byte_order_bit,
    output logic [31:0]      host_index_reg,
    output logic [31:0]      handshake_status_reg,
    input  wire logic        cpu_status_we,
    input  wire logic [31:0] cpu_status_wdata,
    output logic [5:0]       target_code,
    output logic             ext_access,
    output logic             ext_write,
    output logic [31:0]      ext_wdata,
    output logic [31:0]      ext_wmask,
    input  wire logic [31:0] ext_rdata
);
    ////////////////////////////////////////////////////////////////////////
    // strobe synchronisers; first stage is read only by the second
    logic [1:0] wr_sync_q, wr_sync_d;
    logic [1:0] rd_sync_q, rd_sync_d;
    logic       cs_s1_q, cs_s2_q, rs_s1_q, rs_s2_q;
    logic       wr_prev_q, rd_prev_q;
    logic [15:0] bus_s1_q, bus_s2_q;

    always_comb begin
        wr_sync_d = {wr_sync_q[0], ~port.port_write_strobe_n};
        rd_sync_d = {rd_sync_q[0], ~port.port_read_strobe_n};
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_sync_q <= 2'h0;
            rd_sync_q <= 2'h0;
            cs_s1_q   <= 1'b1;
            cs_s2_q   <= 1'b1;
            rs_s1_q   <= 1'b0;
            rs_s2_q   <= 1'b0;
            wr_prev_q <= 1'b0;
            rd_prev_q <= 1'b0;
            bus_s1_q  <= 16'h0000;
            bus_s2_q  <= 16'h0000;
        end else begin
            wr_sync_q <= wr_sync_d;
            rd_sync_q <= rd_sync_d;
            cs_s1_q   <= port.port_chip_select_n;
            cs_s2_q   <= cs_s1_q;
            rs_s1_q   <= port.register_select_pin;
            rs_s2_q   <= rs_s1_q;
            wr_prev_q <= wr_sync_q[1];
            rd_prev_q <= rd_sync_q[1];
            bus_s1_q  <= port.data_bus;
            bus_s2_q  <= bus_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // strobe clash: both strobes low taints the episode until all is quiet again,
    // otherwise releasing both at once would look like a completed write
    logic clash_q, clash_d;

    always_comb begin
        clash_d = (wr_sync_q[1] & rd_sync_q[1]) |
                  (clash_q & (wr_sync_q[1] | rd_sync_q[1] | wr_prev_q | rd_prev_q)); // RQ15
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            clash_q <= 1'b0;
        end else begin
            clash_q <= clash_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // events; write commits on strobe release so data has settled
    logic sel, wr_end, rd_end, both_low;
    always_comb begin
        sel      = ~cs_s2_q;
        both_low = wr_sync_q[1] & rd_sync_q[1];
        wr_end   = sel & wr_prev_q & ~wr_sync_q[1] & ~rd_sync_q[1] & ~clash_q; // RQ16 RQ15
        rd_end   = sel & rd_prev_q & ~rd_sync_q[1] & ~wr_sync_q[1] & ~clash_q; // RQ15
    end

    ////////////////////////////////////////////////////////////////////////
    // index register: only host with select high may write it
    logic [7:0] idx_q, idx_d;
    logic [1:0] half;
    logic       upper_half, is_window, is_status;

    always_comb begin
        half        = idx_q[1:0];
        target_code = idx_q[hpi_pkg::CODE_MSB:hpi_pkg::CODE_LSB]; // RQ5 RQ1
        is_window   = target_code == hpi_pkg::HPI_DATA_WINDOW;
        is_status   = target_code == hpi_pkg::HPI_GEN_STATUS;
        upper_half  = (half == hpi_pkg::HALF_FIRST) ^ byte_order_bit; // RQ7 RQ8
        idx_d       = idx_q;
        if (wr_end && rs_s2_q) begin
            idx_d = bus_s2_q[7:0]; // RQ3 RQ14
        end else if (!rs_s2_q && is_window && (wr_end || rd_end)) begin
            // only 00 and 10 are legal, so flipping bit 1 walks them
            idx_d[1] = ~idx_q[1]; // RQ9
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            idx_q <= hpi_pkg::IDX_RESET;
        end else begin
            idx_q <= idx_d;
        end
    end

    // software sees a read-only copy; no write port exists
    assign host_index_reg = {24'h000000, idx_q}; // RQ2 RQ4

    ////////////////////////////////////////////////////////////////////////
    // handshake status; survives ordinary reset, host write wins over cpu
    logic [15:0] hsk_q, hsk_d;
    logic        host_hsk_we;

    always_comb begin
        host_hsk_we = wr_end & ~rs_s2_q & is_status; // RQ12
        hsk_d       = hsk_q;
        if (cpu_status_we) begin
            hsk_d = cpu_status_wdata[15:0]; // RQ10
        end
        // the upper half holds no bits, so a host write there changes nothing
        if (host_hsk_we && !upper_half) begin
            hsk_d = bus_s2_q; // RQ10 RQ4
        end
    end

    always_ff @(posedge clock or posedge por_rst) begin
        if (por_rst) begin
            hsk_q <= hpi_pkg::HSK_RESET; // RQ13
        end else begin
            hsk_q <= hsk_d;
        end
    end

    assign handshake_status_reg = {16'h0000, hsk_q}; // RQ4

    ////////////////////////////////////////////////////////////////////////
    // indexed access toward the other registers and read data
    logic [31:0] sel_word;
    logic [15:0] rd_half;
    logic [15:0] out_q, out_d;
    logic        oe_q, oe_d;
    // pulses and data leave together from flops so a consumer sees them in one cycle
    logic        ext_access_q, ext_access_d;
    logic        ext_write_q, ext_write_d;
    logic [31:0] ext_wdata_q, ext_wdata_d;
    logic [31:0] ext_wmask_q, ext_wmask_d;

    always_comb begin
        ext_access_d = ~rs_s2_q & ~is_status & (wr_end | rd_end); // RQ14
        ext_write_d  = ext_access_d & wr_end;
        ext_wdata_d  = upper_half ? {bus_s2_q, 16'h0000} : {16'h0000, bus_s2_q}; // RQ7 RQ8
        ext_wmask_d  = upper_half ? 32'hffff0000 : 32'h0000ffff;
        sel_word   = is_status ? handshake_status_reg : ext_rdata;
        rd_half    = upper_half ? sel_word[31:16] : sel_word[15:0];
        if (rs_s2_q) begin
            rd_half = hsk_q; // RQ11
        end
        oe_d  = sel & rd_sync_q[1] & ~both_low;
        out_d = oe_d ? rd_half : out_q;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            out_q        <= 16'h0000;
            oe_q         <= 1'b0;
            ext_access_q <= 1'b0;
            ext_write_q  <= 1'b0;
            ext_wdata_q  <= 32'h00000000;
            ext_wmask_q  <= 32'h00000000;
        end else begin
            out_q        <= out_d;
            oe_q         <= oe_d;
            ext_access_q <= ext_access_d;
            ext_write_q  <= ext_write_d;
            ext_wdata_q  <= ext_wdata_d;
            ext_wmask_q  <= ext_wmask_d;
        end
    end

    assign port.dev_data_out = out_q;
    assign port.dev_data_oe  = oe_q;
    assign ext_access        = ext_access_q;
    assign ext_write         = ext_write_q;
    assign ext_wdata         = ext_wdata_q;
    assign ext_wmask         = ext_wmask_q;
endmodule

// ### hw/hpi_host.sv
// host end: sequences one strobed read or write per request
`timescale 1ns/1ps
module hpi_host (
    input  wire logic        clock,
    input  wire logic        rst,
    hpi_if.host              port,
    input  wire logic        req_valid,
    input  wire logic        req_write,
    input  wire logic        req_direct,
    input  wire logic [15:0] req_wdata,
    output logic             req_ready,
    output logic             rsp_valid,
    output logic [15:0]      rsp_rdata
);
    hpi_pkg::hpi_host_state_t st_q, st_d;
    logic [3:0]  cnt_q, cnt_d;
    logic        wr_q, wr_d, dir_q, dir_d;
    logic [15:0] wd_q, wd_d, rd_q, rd_d;
    logic        rv_q, rv_d;

    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        wr_d  = wr_q;
        dir_d = dir_q;
        wd_d  = wd_q;
        rd_d  = rd_q;
        rv_d  = 1'b0;
        case (st_q)
            hpi_pkg::HPI_IDLE: begin
                if (req_valid) begin
                    // caller must keep the index codes and half selectors legal
                    wr_d  = req_write; // RQ6
                    dir_d = req_direct; // RQ12
                    wd_d  = req_wdata;
                    st_d  = hpi_pkg::HPI_SETUP;
                end
            end
            hpi_pkg::HPI_SETUP: begin
                cnt_d = hpi_pkg::STROBE_CNT;
                st_d  = hpi_pkg::HPI_STROBE;
            end
            hpi_pkg::HPI_STROBE: begin
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h1) begin
                    rd_d = port.data_bus;
                    st_d = hpi_pkg::HPI_HOLD;
                end
            end
            hpi_pkg::HPI_HOLD: begin
                rv_d = ~wr_q;
                st_d = hpi_pkg::HPI_IDLE;
            end
            default: st_d = hpi_pkg::HPI_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_q  <= hpi_pkg::HPI_IDLE;
            cnt_q <= 4'h0;
            wr_q  <= 1'b0;
            dir_q <= 1'b0;
            wd_q  <= 16'h0000;
            rd_q  <= 16'h0000;
            rv_q  <= 1'b0;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            wr_q  <= wr_d;
            dir_q <= dir_d;
            wd_q  <= wd_d;
            rd_q  <= rd_d;
            rv_q  <= rv_d;
        end
    end

    logic active, strobing;
    assign active   = st_q != hpi_pkg::HPI_IDLE;
    assign strobing = st_q == hpi_pkg::HPI_STROBE;
    assign port.port_chip_select_n  = ~active; // RQ15
    assign port.register_select_pin = active & dir_q; // RQ3 RQ11 RQ14
    // never both strobes low at once
    assign port.port_write_strobe_n = ~(strobing & wr_q); // RQ15
    assign port.port_read_strobe_n  = ~(strobing & ~wr_q);
    assign port.host_data_out       = wd_q; // RQ4
    assign port.host_data_oe        = active & wr_q;
    assign req_ready = ~active;
    assign rsp_valid = rv_q;
    assign rsp_rdata = rd_q;
endmodule

// ### verification/hpi_monitor.sv
// checker on the wires between host end and device end
`timescale 1ns/1ps
module hpi_monitor (
    input wire logic clock,
    input wire logic rst,
    input wire logic port_chip_select_n,
    input wire logic register_select_pin,
    input wire logic port_write_strobe_n,
    input wire logic port_read_strobe_n,
    input wire logic host_data_oe,
    input wire logic dev_data_oe
);
    logic cs;
    logic wr;
    logic rd;
    assign cs = !port_chip_select_n;
    assign wr = !port_write_strobe_n;
    assign rd = !port_read_strobe_n;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    AST_NO_DOUBLE_STROBE: assert property (!(wr && rd))
        else $error("both strobes low");
    AST_STROBE_IN_CS: assert property ((wr || rd) |-> cs)
        else $error("strobe outside chip select");
    AST_NO_FIGHT: assert property (!(host_data_oe && dev_data_oe))
        else $error("both ends drive the bus");
    AST_WR_DRIVEN: assert property (wr |-> host_data_oe)
        else $error("write strobe with undriven bus");
    AST_WR_WIDTH: assert property ($rose(wr) |=> wr [*3] ##1 !wr)
        else $error("write strobe width wrong");
    AST_DEV_ANSWERS: assert property ($rose(rd) |-> ##[1:3] dev_data_oe)
        else $error("device did not answer read");
    AST_DEV_ONLY_READ: assert property ($rose(dev_data_oe) |-> $past(rd))
        else $error("device drove bus outside read");
    AST_DEV_RELEASE: assert property ($fell(rd) |-> ##[1:4] !dev_data_oe)
        else $error("device kept bus after read");
    AST_RS_STEADY: assert property (wr && $past(wr) |-> $stable(register_select_pin))
        else $error("select moved during write");
    cover property (cs && wr && register_select_pin);
    cover property (cs && wr && !register_select_pin);
    cover property (cs && rd && register_select_pin);
    cover property (cs && rd && !register_select_pin);
endmodule

// ### verification/host_port_index_and_status_tb.sv
// host end and device end face to face, plus a lone device for bad strobes
`timescale 1ns/1ps
module host_port_index_and_status_tb;
    logic        clock = 0, rst = 1, por_rst = 1, byte_order_bit = 0, cpu_status_we = 0;
    logic [31:0] cpu_status_wdata = 0, ext_rdata = 32'h12345678, idx, gsr, idx2;
    logic        req_valid = 0, req_write = 0, req_direct = 0, req_ready, rsp_valid;
    logic [15:0] req_wdata = 0, rsp_rdata, r;
    logic [5:0]  code;
    logic [5:0]  codes [8] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h0f};
    int          failures = 0, n_compared = 0;
    logic        ext_acc, ext_wr;
    logic [31:0] ext_wd, ext_wm, wd_seen = 0, wm_seen = 0;
    int          n_ext_wr = 0, n_ext_acc = 0;
    always #50 clock = ~clock;
    hpi_if bus ();
    hpi_if bus2 ();
    hpi_host hpi_host_inst (.clock, .rst, .port(bus), .req_valid, .req_write, .req_direct,
        .req_wdata, .req_ready, .rsp_valid, .rsp_rdata);
    hpi_device hpi_device_inst (.clock, .rst, .por_rst, .port(bus), .byte_order_bit,
        .host_index_reg(idx), .handshake_status_reg(gsr), .cpu_status_we, .cpu_status_wdata,
        .target_code(code), .ext_access(ext_acc), .ext_write(ext_wr), .ext_wdata(ext_wd),
        .ext_wmask(ext_wm), .ext_rdata);
    hpi_device hpi_device_inst_2 (.clock, .rst, .por_rst, .port(bus2), .byte_order_bit,
        .host_index_reg(idx2), .handshake_status_reg(), .cpu_status_we, .cpu_status_wdata,
        .target_code(), .ext_access(), .ext_write(), .ext_wdata(), .ext_wmask(), .ext_rdata);
    hpi_monitor hpi_monitor_inst (.clock, .rst,
        .port_chip_select_n(bus.port_chip_select_n), .register_select_pin(bus.register_select_pin),
        .port_write_strobe_n(bus.port_write_strobe_n), .port_read_strobe_n(bus.port_read_strobe_n),
        .host_data_oe(bus.host_data_oe), .dev_data_oe(bus.dev_data_oe));
    // indexed-access pulses toward the other registers, seen from outside
    always @(posedge clock) begin
        if (ext_acc === 1'b1) begin
            n_ext_acc <= n_ext_acc + 1;
        end
        if (ext_wr === 1'b1) begin
            n_ext_wr <= n_ext_wr + 1;
            wd_seen  <= ext_wd;
            wm_seen  <= ext_wm;
        end
    end
    ////////////////////////////////////////
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (e !== g) begin
            failures++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one host transfer; w=write, d=register select high
    task automatic acc(input logic w, input logic d, input logic [15:0] wd);
        int i;
        @(posedge clock);
        #10;
        for (i = 0; i < 20 && req_ready !== 1'b1; i++) begin
            @(posedge clock);
            #10;
        end
        if (req_ready !== 1'b1) begin
            failures++;
            wrap_up();
        end
        req_valid = 1;
        req_write = w;
        req_direct = d;
        req_wdata = wd;
        @(posedge clock);
        #10;
        req_valid = 0;
        // a write has no response: its end is the host going idle again
        for (i = 0; i < 20 && (w ? req_ready : rsp_valid) !== 1'b1; i++) @(negedge clock);
        if ((w ? req_ready : rsp_valid) !== 1'b1) begin
            failures++;
            wrap_up();
        end else begin
            r = rsp_rdata;
        end
        // device commits three cycles after the host lets go, its output flops load on that same edge
        repeat (4) @(posedge clock);
        #10;
    endtask
    // lone device: pins held for six cycles, long enough to pass the synchroniser
    task automatic drv2(input logic [3:0] p);
        {bus2.port_chip_select_n, bus2.register_select_pin} = p[3:2];
        {bus2.port_write_strobe_n, bus2.port_read_strobe_n} = p[1:0];
        repeat (6) @(posedge clock);
        #10;
    endtask
    ////////////////////////////////////////
    initial begin
        bus2.host_data_out = 16'h00ff;
        bus2.host_data_oe = 1;
        {bus2.port_chip_select_n, bus2.register_select_pin} = 2'h3;
        {bus2.port_write_strobe_n, bus2.port_read_strobe_n} = 2'h3;
        repeat (4) @(posedge clock);
        #10;
        rst = 0;
        por_rst = 0;
        chk("index", 0, idx);
        chk("status", 0, gsr);
        acc(1, 1, 16'h0002);
        chk("index", 32'h2, idx);
        acc(1, 0, 16'ha5c3);
        chk("status", 32'ha5c3, gsr);
        chk("index", 32'h2, idx);
        acc(0, 1, 0);
        chk("direct read", 16'ha5c3, r);
        acc(0, 0, 0);
        chk("indexed read", 16'ha5c3, r);
        acc(1, 1, 16'h0000);
        acc(0, 0, 0);
        chk("upper half", 0, r);
        acc(1, 0, 16'h0000);
        chk("status kept", 32'ha5c3, gsr);
        byte_order_bit = 1;
        acc(0, 0, 0);
        chk("order set", 16'ha5c3, r);
        $display("test status done");
        acc(1, 1, 16'h0018);
        acc(0, 0, 0);
        chk("window", 16'h5678, r);
        chk("index", 32'h1a, idx);
        acc(0, 0, 0);
        chk("window", 16'h1234, r);
        chk("index", 32'h18, idx);
        acc(1, 0, 16'h0bad);
        chk("index", 32'h1a, idx);
        chk("ext writes", 1, n_ext_wr);
        chk("ext wdata", 32'h00000bad, wd_seen);
        chk("ext wmask", 32'h0000ffff, wm_seen);
        chk("ext accesses", 3, n_ext_acc);
        byte_order_bit = 0;
        $display("test window done");
        for (int k = 0; k < 8; k++) begin
            acc(1, 1, {8'h00, codes[k], 2'b10});
            chk("code", codes[k], code);
            chk("index", {24'h0, codes[k], 2'b10}, idx);
        end
        $display("test codes done");
        cpu_status_wdata = 32'hffff1234;
        cpu_status_we = 1;
        @(posedge clock);
        #10;
        cpu_status_we = 0;
        chk("cpu status", 32'h1234, gsr);
        acc(0, 1, 0);
        chk("host sees", 16'h1234, r);
        rst = 1;
        @(posedge clock);
        #10;
        rst = 0;
        chk("kept status", 32'h1234, gsr);
        chk("index", 0, idx);
        {rst, por_rst} = 2'h3;
        @(posedge clock);
        #10;
        {rst, por_rst} = 2'h0;
        chk("por status", 0, gsr);
        $display("test resets done");
        drv2(4'b1101);
        drv2(4'b1111);
        chk("nop index", 0, idx2);
        drv2(4'b0100);
        drv2(4'b0111);
        chk("both low index", 0, idx2);
        $display("test bad strobes done");
        wrap_up();
    end
endmodule
